/* core/dps_regs.svh */
// constants for one port of the dual-port memory control block
// assumes the includer uses the dps_ names and a single port clock
`ifndef DPS_REGS_SVH
`define DPS_REGS_SVH

`define DPS_LANE_W   9
`define DPS_LANES    2
`define DPS_DATA_W   18
`define DPS_ADDR_W   18
`define DPS_ADDR_RST 18'h0_0000
`define DPS_LAT_FT   1
`define DPS_LAT_PL   2

`endif

/* core/dps_pkg.sv */
// types shared by the port control files
// assumes dps_regs.svh is on the include path
`include "dps_regs.svh"

package dps_pkg;

  // synchronous access controls sampled at the rising edge
  typedef struct packed {
    logic select_low_active;
    logic select_high_active;
    logic read_not_write;
    logic upper_lane_enable_n;
    logic lower_lane_enable_n;
  } dps_ctl_t;

  // address counter controls
  typedef struct packed {
    logic address_strobe_n;
    logic count_enable_n;
    logic repeat_n;
  } dps_ctr_t;

  // output timing selected by output_register_select
  typedef enum logic {
    DPS_FLOW,
    DPS_PIPE
  } dps_out_mode_t;

endpackage

/* core/dps_addr_ctr.sv */
// burst address counter with strobe load, hold, count and repeat
// assumes controls are synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
`include "dps_regs.svh"

module dps_addr_ctr
  import dps_pkg::*;
#(
  parameter int AW = `DPS_ADDR_W
) (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          clk_en,
  input  wire dps_ctr_t      ctr,
  input  wire logic [AW-1:0] ext_addr,
  output logic      [AW-1:0] addr_q
);

  logic [AW-1:0] addr_r;
  logic [AW-1:0] addr_nxt;
  logic [AW-1:0] rpt_r;
  logic [AW-1:0] rpt_nxt;

  // no select or lane term here: counter runs even when deselected
  always_comb begin
    addr_nxt = addr_r;
    rpt_nxt  = rpt_r;
    if (clk_en) begin
      if (!ctr.repeat_n) begin
        addr_nxt = rpt_r;
      end else if (!ctr.address_strobe_n) begin
        addr_nxt = ext_addr;
        rpt_nxt  = ext_addr;
      end else if (!ctr.count_enable_n) begin
        addr_nxt = addr_r + 1'b1;
      end else begin
        addr_nxt = addr_r;
      end
    end
  end

  // counter state; repeat address below keeps no reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr_r <= AW'(`DPS_ADDR_RST);
    end else begin
      addr_r <= addr_nxt;
    end
  end

  // left unreset on purpose: undefined until first strobe load
  always_ff @(posedge mclk) begin
    rpt_r <= rpt_nxt;
  end

  assign addr_q = addr_r;

endmodule
`default_nettype wire

/* core/dps_lane_dec.sv */
// decodes selects, direction and lane enables into lane requests
// assumes inputs are the controls sampled this cycle
`timescale 1ns/1ps
`default_nettype none
`include "dps_regs.svh"

module dps_lane_dec
  import dps_pkg::*;
(
  input  wire dps_ctl_t               ctl,
  output logic                        selected,
  output logic [`DPS_LANES-1:0]       wr_lane,
  output logic [`DPS_LANES-1:0]       rd_lane
);

  logic [`DPS_LANES-1:0] lane_on;

  // both selects must agree, else power-down with lanes floating
  assign selected = !ctl.select_low_active
                  && ctl.select_high_active;

  // lane 0 is bits 0-8, lane 1 is bits 9-17
  assign lane_on = {~ctl.upper_lane_enable_n,
                    ~ctl.lower_lane_enable_n};

  // one request per lane, direction splits write from read
  genvar i;
  generate
    for (i = 0; i < `DPS_LANES; i++) begin : g_lane
      assign wr_lane[i] = selected && lane_on[i]
                        && !ctl.read_not_write;
      assign rd_lane[i] = selected && lane_on[i]
                        && ctl.read_not_write;
    end
  endgenerate

endmodule
`default_nettype wire

/* core/dps_port.sv */
// one port of the dual-port memory: control, counter, output timing
// assumes the array is outside, written and read at mem_addr;
// mem_rdata is combinational from mem_addr within one cycle
`timescale 1ns/1ps
`default_nettype none
`include "dps_regs.svh"

module dps_port
  import dps_pkg::*;
#(
  parameter int AW = `DPS_ADDR_W,
  parameter int LW = `DPS_LANE_W,
  parameter int DW = `DPS_DATA_W
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  input  wire dps_ctl_t              ctl,
  input  wire dps_ctr_t              ctr,
  input  wire logic                  output_enable_n,
  input  wire logic                  output_register_select,
  input  wire logic [AW-1:0]         ext_addr,
  input  wire logic [DW-1:0]         dq_in,
  output logic      [DW-1:0]         dq_out,
  output logic      [`DPS_LANES-1:0] dq_oe,
  output logic      [AW-1:0]         mem_addr,
  output logic      [`DPS_LANES-1:0] mem_wr_lane,
  output logic      [DW-1:0]         mem_wdata,
  input  wire logic [DW-1:0]         mem_rdata,
  output logic                       port_active
);

  // this module is one port; a second instance on its own clock
  // forms the other port and only the array is shared

  // decoded requests for the current edge
  logic                  sel_now;
  logic [`DPS_LANES-1:0] wr_now;
  logic [`DPS_LANES-1:0] rd_now;

  // first register stage: write, read lanes, select
  logic [`DPS_LANES-1:0] wr_lane_r;
  logic [`DPS_LANES-1:0] wr_lane_nxt;
  logic [DW-1:0]         wdata_r;
  logic [DW-1:0]         wdata_nxt;
  logic [`DPS_LANES-1:0] rd1_r;
  logic [`DPS_LANES-1:0] rd1_nxt;
  logic                  sel_r;
  logic                  sel_nxt;

  // second stage used only in pipelined mode
  logic [`DPS_LANES-1:0] rd2_r;
  logic [`DPS_LANES-1:0] rd2_nxt;
  logic [DW-1:0]         rdat2_r;
  logic [DW-1:0]         rdat2_nxt;

  // output stage
  logic [`DPS_LANES-1:0] lane_r;
  logic [`DPS_LANES-1:0] lane_nxt;
  logic [DW-1:0]         dout_r;
  logic [DW-1:0]         dout_nxt;

  dps_out_mode_t         mode;

  // selects and lanes decoded from the sampled controls
  dps_lane_dec u_dec (
    .ctl      (ctl),
    .selected (sel_now),
    .wr_lane  (wr_now),
    .rd_lane  (rd_now)
  );

  // counter sees no select or lane input at all
  dps_addr_ctr #(
    .AW (AW)
  ) u_ctr (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .ctr      (ctr),
    .ext_addr (ext_addr),
    .addr_q   (mem_addr)
  );

  // mode pin high means pipelined output register in use
  assign mode = output_register_select ? DPS_PIPE : DPS_FLOW;

  // first stage: capture requests at the edge
  always_comb begin
    wr_lane_nxt = wr_lane_r;
    rd1_nxt     = rd1_r;
    sel_nxt     = sel_r;
    if (clk_en) begin
      wr_lane_nxt = wr_now;
      rd1_nxt     = rd_now;
      sel_nxt     = sel_now;
    end
  end

  // requests clear at reset so no stray write reaches the array
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_lane_r <= '0;
      wdata_r   <= '0;
      rd1_r     <= '0;
      sel_r     <= 1'b0;
    end else begin
      wr_lane_r <= wr_lane_nxt;
      wdata_r   <= wdata_nxt;
      rd1_r     <= rd1_nxt;
      sel_r     <= sel_nxt;
    end
  end

  // second stage: the extra cycle of the pipelined path
  always_comb begin
    rd2_nxt   = rd2_r;
    rdat2_nxt = rdat2_r;
    if (clk_en) begin
      rd2_nxt   = rd1_r;
      rdat2_nxt = mem_rdata;
    end
  end

  // second stage registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd2_r   <= '0;
      rdat2_r <= '0;
    end else begin
      rd2_r   <= rd2_nxt;
      rdat2_r <= rdat2_nxt;
    end
  end

  // output stage picks the flow-through or pipelined source;
  // in pipelined mode lanes pass three stages, so deselect lags
  always_comb begin
    lane_nxt = lane_r;
    dout_nxt = dout_r;
    if (clk_en) begin
      case (mode)
        DPS_FLOW: begin
          lane_nxt = rd1_r;
          dout_nxt = mem_rdata;
        end
        DPS_PIPE: begin
          lane_nxt = rd2_r;
          dout_nxt = rdat2_r;
        end
        default: begin
          lane_nxt = '0;
          dout_nxt = dout_r;
        end
      endcase
    end
  end

  // output registers; lanes start floating after reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lane_r <= '0;
      dout_r <= '0;
    end else begin
      lane_r <= lane_nxt;
      dout_r <= dout_nxt;
    end
  end

  // data and array write side come straight from registers
  assign dq_out      = dout_r;
  assign mem_wr_lane = wr_lane_r;
  assign mem_wdata   = wdata_r;
  assign port_active = sel_r;

  // output enable gates each lane with no clock in the path;
  // this is the one output not taken purely from a flop
  genvar i;
  generate
    for (i = 0; i < `DPS_LANES; i++) begin : g_oe
      assign dq_oe[i] = lane_r[i] && !output_enable_n;
    end
  endgenerate

  // write data loads per lane only when that lane is written,
  // so idle lanes leave the array data inputs quiet
  generate
    for (i = 0; i < `DPS_LANES; i++) begin : g_wd
      assign wdata_nxt[i*LW +: LW] = (clk_en && wr_now[i])
                                   ? dq_in[i*LW +: LW]
                                   : wdata_r[i*LW +: LW];
    end
  endgenerate

endmodule
`default_nettype wire

/* tb/dps_port_monitor.sv */
// assertions on one port: lane gating, counter, output timing
// assumes dps_port ports and one clock, mclk
`timescale 1ns/1ps
`default_nettype none
module dps_port_monitor
  import dps_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire dps_ctl_t    ctl,
  input wire dps_ctr_t    ctr,
  input wire logic        output_enable_n,
  input wire logic        output_register_select,
  input wire logic [17:0] ext_addr,
  input wire logic [17:0] mem_addr,
  input wire logic [1:0]  mem_wr_lane,
  input wire logic [1:0]  dq_oe
);
  logic [17:0] last_r;
  logic [17:0] last_nxt;
  logic        seen_r;
  logic        seen_nxt;
  wire logic   go = rst_n && clk_en;
  wire logic   sel = !ctl.select_low_active && ctl.select_high_active;
  wire logic   rd = sel && ctl.read_not_write;
  wire logic   ors = output_register_select;
  wire logic [1:0] lanes = ~{ctl.upper_lane_enable_n,
                             ctl.lower_lane_enable_n};

  // shadow of the repeat address; unknown until a first load
  always_comb begin
    last_nxt = last_r;
    seen_nxt = seen_r;
    if (go && !ctr.address_strobe_n && ctr.repeat_n) begin
      last_nxt = ext_addr;
      seen_nxt = 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    last_r <= last_nxt;
    seen_r <= rst_n ? seen_nxt : 1'b0;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_oe_off; output_enable_n |-> dq_oe == 2'h0; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("lanes driven while outputs disabled");
  property p_no_wr; go && !sel |=> mem_wr_lane == 2'h0; endproperty
  a_no_wr: assert property (p_no_wr)
    else $error("write while deselected");
  property p_wr;
    go && sel && !ctl.read_not_write |=> mem_wr_lane == $past(lanes);
  endproperty
  a_wr: assert property (p_wr)
    else $error("write lanes wrong");
  property p_load;
    go && ctr.repeat_n && !ctr.address_strobe_n
      |=> mem_addr == $past(ext_addr);
  endproperty
  a_load: assert property (p_load)
    else $error("strobe load missed");
  property p_count;
    go && ctr == 3'h5 |=> mem_addr == $past(mem_addr) + 18'h1;
  endproperty
  a_count: assert property (p_count)
    else $error("counter did not advance");
  property p_hold; go && ctr == 3'h7 |=> $stable(mem_addr); endproperty
  a_hold: assert property (p_hold)
    else $error("address moved on hold");
  property p_repeat;
    go && seen_r && !ctr.repeat_n |=> mem_addr == $past(last_r);
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("repeat address wrong");
  property p_flow;
    go && rd && !ors ##1 go && !ors
      |=> output_enable_n || dq_oe == $past(lanes, 2);
  endproperty
  a_flow: assert property (p_flow)
    else $error("flow read lanes wrong");
  property p_pipe;
    go && rd && ors ##1 (go && ors)[*2]
      |=> output_enable_n || dq_oe == $past(lanes, 3);
  endproperty
  a_pipe: assert property (p_pipe)
    else $error("pipelined read lanes wrong");
  property p_pipe_off;
    go && !sel && ors ##1 (go && ors)[*2] |=> dq_oe == 2'h0;
  endproperty
  a_pipe_off: assert property (p_pipe_off)
    else $error("pipelined deselect late");
endmodule

bind dps_port dps_port_monitor u_dps_port_monitor (
  .mclk, .rst_n, .clk_en, .ctl, .ctr, .output_enable_n,
  .output_register_select, .ext_addr, .mem_addr, .mem_wr_lane, .dq_oe
);
`default_nettype wire

/* tb/dps_mem_model.sv */
// storage array behind one port, byte lanes written separately
// assumes writes land at the edge while the lane strobe is high
`timescale 1ns/1ps
`default_nettype none
module dps_mem_model (
  input  wire logic        mclk,
  input  wire logic [17:0] mem_addr,
  input  wire logic [1:0]  mem_wr_lane,
  input  wire logic [17:0] mem_wdata,
  output logic      [17:0] mem_rdata
);
  logic [17:0] mem [0:262143];
  // unwritten lanes read unknown, as real cells would
  always @(posedge mclk) begin
    if (mem_wr_lane[0]) mem[mem_addr][8:0] <= mem_wdata[8:0];
    if (mem_wr_lane[1]) mem[mem_addr][17:9] <= mem_wdata[17:9];
  end
  assign mem_rdata = mem[mem_addr];
endmodule
`default_nettype wire

/* tb/dps_port_tb.sv */
// self-checking bench for one port with an array model behind it
// assumes one 250 MHz clock; the other port is absent
`timescale 1ns/1ps
`default_nettype none
module dps_port_tb;
  import dps_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic        oe_n = 1'b0;
  logic        ors = 1'b0;
  dps_ctl_t    ctl = 5'h17;
  dps_ctr_t    ctr = 3'h7;
  logic [17:0] addr = 18'h0;
  logic [17:0] din = 18'h0;
  logic [17:0] dq_out, maddr, mwd, mrd;
  logic [1:0]  dq_oe, mwl;
  logic        act;
  int          err_total = 0;
  int          checks = 0;

  always #2 mclk = ~mclk;

  dps_port u_dps_port (
    .mclk, .rst_n, .clk_en, .ctl, .ctr, .output_enable_n(oe_n),
    .output_register_select(ors), .ext_addr(addr), .dq_in(din),
    .dq_out, .dq_oe, .mem_addr(maddr), .mem_wr_lane(mwl),
    .mem_wdata(mwd), .mem_rdata(mrd), .port_active(act)
  );
  dps_mem_model u_dps_mem_model (
    .mclk, .mem_addr(maddr), .mem_wr_lane(mwl), .mem_wdata(mwd),
    .mem_rdata(mrd)
  );

  task automatic chk(string n, logic [17:0] s, logic [17:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask

  // one request, sampled at the following edge
  task automatic step(logic [4:0] c, logic [2:0] r, logic [17:0] a,
                      logic [17:0] d);
    @(posedge mclk);
    ctl <= c;
    ctr <= r;
    addr <= a;
    din <= d;
  endtask

  task automatic idle;
    step(5'h17, 3'h7, 18'h0, 18'h0);
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (500) @(posedge mclk);
    err_total++;
    results;
  end

  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    #1 chk("rst oe", 18'(dq_oe), 18'h0);
    chk("rst act", 18'(act), 18'h0);
    chk("rst lane", 18'(mwl), 18'h0);
    step(5'h08, 3'h3, 18'h5, 18'h2a5a5);
    step(5'h0a, 3'h5, 18'h3ffff, 18'h1ffff);
    #1 chk("addr", maddr, 18'h5);
    chk("lane", 18'(mwl), 18'h3);
    chk("wdata", mwd, 18'h2a5a5);
    chk("act", 18'(act), 18'h1);
    step(5'h09, 3'h5, 18'h0, 18'h3fe00);
    #1 chk("addr", maddr, 18'h6);
    chk("lane", 18'(mwl), 18'h1);
    step(5'h00, 3'h5, 18'h0, 18'h0);
    #1 chk("addr", maddr, 18'h7);
    chk("lane", 18'(mwl), 18'h2);
    step(5'h17, 3'h2, 18'h100, 18'h0);
    #1 chk("addr", maddr, 18'h8);
    chk("lane", 18'(mwl), 18'h0);
    chk("act", 18'(act), 18'h0);
    step(5'h0c, 3'h7, 18'h100, 18'h0);
    #1 chk("addr", maddr, 18'h5);
    idle;
    #1 chk("addr", maddr, 18'h5);
    idle;
    #1 chk("dout", dq_out, 18'h2a5a5);
    chk("oe", 18'(dq_oe), 18'h3);
    idle;
    #1 chk("oe", 18'(dq_oe), 18'h0);
    step(5'h0d, 3'h3, 18'h7, 18'h0);
    ors <= 1'b1;
    idle;
    idle;
    #1 chk("oe", 18'(dq_oe), 18'h0);
    idle;
    #1 chk("oe", 18'(dq_oe), 18'h2);
    chk("dout", 18'(dq_out[17:9]), 18'h1ff);
    oe_n <= 1'b1;
    #1 chk("oe", 18'(dq_oe), 18'h0);
    oe_n <= 1'b0;
    idle;
    #1 chk("oe", 18'(dq_oe), 18'h0);
    // count request while frozen: nothing may move until enable returns
    step(5'h17, 3'h5, 18'h0, 18'h0);
    clk_en <= 1'b0;
    step(5'h17, 3'h5, 18'h0, 18'h0);
    clk_en <= 1'b1;
    #1 chk("freeze addr", maddr, 18'h7);
    idle;
    #1 chk("count addr", maddr, 18'h8);
    results;
  end
endmodule
`default_nettype wire
